// ---- testbench/mss_switch_model.sv ----
// switch model: operator switches wired to the selector's input terminals
`timescale 1ns/1ps
module mss_switch_model (
	input  wire logic        pclk,
	input  wire logic [3:0]  sel,
	input  wire logic [15:0] wiring,
	output logic      [5:0]  term_in
);
	logic [5:0] closed;

	// wired select bits close a switch, open switches read low
	always_comb
	begin
		closed = 6'h00;
		for (int b = 0; b < 4; b++)
			if (wiring[4*b+3] && int'(wiring[4*b +: 3]) < 6)
				closed[wiring[4*b +: 3]] = sel[b];
	end

	// switches move just after an edge, like any other driver
	always_ff @(posedge pclk)
		term_in <= closed;
endmodule

// ---- testbench/tb.sv ----
// testbench: apb register access and switch-driven speed selection
`timescale 1ns/1ps
module tb;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [5:0]  term_in;
	logic [15:0] mon;
	logic [3:0]  speed_index;
	logic [3:0]  sel     = 4'h0;
	logic [15:0] wiring  = 16'hba98;
	logic [31:0] rd;
	logic        serr;
	int          err_total   = 0;
	int          comparisons = 0;

	always #12.5 pclk = ~pclk;

	mss_top i_mss_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .term_in, .output_frequency_monitor(mon), .speed_index);
	mss_switch_model i_mss_switch_model (.pclk, .sel, .wiring, .term_in);

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] v(input int k);
		return 32'h100 + 32'(17 * k);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, entered just after an edge; holds until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		serr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// sync plus decode takes up to six cycles, eight leaves margin
	task automatic pick(input logic [3:0] i);
		sel <= i;
		repeat (8) @(posedge pclk);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// about 340 cycles of tests, so 100 us is a hang
	initial
	begin
		#100us;
		err_total++;
		tally_and_finish();
	end

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc(mss_pkg::OFF_MAXF, 32'h1770);
		rc(mss_pkg::OFF_TERMMAP, 32'hba98);
		rc(12'h020, 32'h0);
		chk({31'h0, serr}, 32'h1);
		for (int k = 0; k < 16; k++)
			apb(1'b1, mss_pkg::OFF_SLOT0 + 12'(4 * k), v(k));
		for (int k = 0; k < 16; k++)
			rc(mss_pkg::OFF_SLOT0 + 12'(4 * k), v(k));
		apb(1'b1, mss_pkg::OFF_CTRL, 32'h1);
		rc(mss_pkg::OFF_CTRL, 32'h1);
		for (int k = 0; k < 16; k++)
		begin
			pick(4'(k));
			chk(32'(speed_index), 32'(k));
			chk(32'(mon), v(k));
		end
		// bit0 moved to terminal 5, bit3 left unassigned but its switch closed
		apb(1'b1, mss_pkg::OFF_TERMMAP, 32'h3a9d);
		wiring <= 16'hba9d;
		pick(4'hf);
		chk(32'(speed_index), 32'h7);
		chk(32'(mon), v(7));
		wiring <= 16'hba98;
		apb(1'b1, mss_pkg::OFF_TERMMAP, 32'hba98);
		apb(1'b1, mss_pkg::OFF_MAXF, 32'h120);
		pick(4'hf);
		chk(32'(mon), 32'h120);
		rc(mss_pkg::OFF_ACTIVE, 32'h120);
		rc(mss_pkg::OFF_STATUS, 32'h10f);
		rc(mss_pkg::OFF_MONITOR, 32'h120);
		pick(4'h1);
		chk(32'(mon), v(1));
		apb(1'b1, mss_pkg::OFF_MAXF, 32'h1770);
		apb(1'b1, mss_pkg::OFF_CTRL, 32'h0);
		pick(4'h6);
		chk(32'(mon), 32'h0);
		rc(mss_pkg::OFF_EDIT, v(6));
		apb(1'b1, mss_pkg::OFF_EDIT, 32'habc);
		rc(mss_pkg::OFF_SLOT0 + 12'h018, v(6));
		apb(1'b1, mss_pkg::OFF_STORE, 32'h10);
		rc(mss_pkg::OFF_SLOT0 + 12'h018, 32'habc);
		rc(mss_pkg::OFF_ACTIVE, 32'habc);
		apb(1'b1, mss_pkg::OFF_EDIT, 32'hdef);
		apb(1'b1, mss_pkg::OFF_STORE, 32'h2);
		rc(mss_pkg::OFF_SLOT0 + 12'h008, 32'hdef);
		apb(1'b1, mss_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, mss_pkg::OFF_EDIT, 32'h111);
		apb(1'b1, mss_pkg::OFF_STORE, 32'h10);
		rc(mss_pkg::OFF_SLOT0 + 12'h018, 32'habc);
		chk(32'(mon), 32'habc);
		tally_and_finish();
	end
endmodule

// ---- verilog/mss_pkg.sv ----
// shared constants and carrier types for the multi-speed selector
package mss_pkg;
	localparam int          NUM_SLOTS    = 16;
	localparam int          SEL_BITS     = 4;
	localparam int          NUM_TERMS    = 6;
	localparam int          FREQ_W       = 16;
	// register byte offsets
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_STATUS   = 12'h004;
	localparam logic [11:0] OFF_MAXF     = 12'h008;
	localparam logic [11:0] OFF_TERMMAP  = 12'h00c;
	localparam logic [11:0] OFF_EDIT     = 12'h010;
	localparam logic [11:0] OFF_STORE    = 12'h014;
	localparam logic [11:0] OFF_ACTIVE   = 12'h018;
	localparam logic [11:0] OFF_MONITOR  = 12'h01c;
	localparam logic [11:0] OFF_SLOT0    = 12'h040;
	localparam logic [11:0] OFF_SLOT_END = 12'h07c;
	// field positions
	localparam int          CTRL_RUN     = 0;
	localparam int          STORE_BY_SEL = 4;
	localparam int          TERM_FLD_W   = 4;
	// reset values
	localparam logic [15:0] MAXF_RST     = 16'h1770;
	localparam logic [15:0] SLOT_RST     = 16'h0000;
	// each select bit: enable bit then three-bit terminal index
	localparam logic [15:0] TERMMAP_RST  = 16'hba98;
	localparam int          SYNC_STAGES  = 3;

	typedef struct packed {
		logic        run;
		logic [15:0] maxf;
		logic [15:0] termmap;
	} mss_cfg_t;
endpackage

// ---- verilog/mss_top.sv ----
// multi-speed selector: slot table, terminal mapping, select decode, apb registers
// What this block does
// - sixteen slots, one drives run frequency
// - four select inputs form binary index
// - index picks slot, zero picks slot zero
// - any select bit maps to any terminal
// - fewer inputs use low bits, low slots
// - selection changes follow live while running
// - each slot individually programmable
// - edits commit only on store press
// - output never exceeds maximum frequency limit
// - monitor tracks selected slot output frequency
// - in stop, newly selected slot loaded for editing
// - in stop, store writes edit to selected slot
`timescale 1ns/1ps
module mss_top #(
	parameter int NUM_TERMS = mss_pkg::NUM_TERMS,
	parameter int FREQ_W    = mss_pkg::FREQ_W
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	input  wire logic [NUM_TERMS-1:0] term_in,
	output logic [FREQ_W-1:0]         output_frequency_monitor,
	output logic [3:0]                speed_index
);

	////////////////////////////////////////////////////////////////////
	// terminal synchronisers
	logic [NUM_TERMS-1:0] sync1_r;
	logic [NUM_TERMS-1:0] sync2_r;
	logic [NUM_TERMS-1:0] sync3_r;
	logic [NUM_TERMS-1:0] term_r;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			term_r  <= '0;
		end
		else
		begin
			sync1_r <= term_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			for (int i = 0; i < NUM_TERMS; i++)
				if (sync2_r[i] == sync3_r[i])
					term_r[i] <= sync3_r[i];
		end
	end

	////////////////////////////////////////////////////////////////////
	// configuration registers
	mss_pkg::mss_cfg_t        cfg_r;
	logic [FREQ_W-1:0]        edit_r;
	logic [FREQ_W-1:0]        slot_r [mss_pkg::NUM_SLOTS];
	logic [FREQ_W-1:0]        active_r;
	logic [3:0]               sel_nxt;

	logic                     wr_en;
	logic                     rd_en;
	logic                     slot_hit;
	logic [3:0]               slot_addr;
	assign wr_en     = psel && penable && pwrite;
	assign rd_en     = psel && penable && !pwrite;
	assign slot_hit  = (paddr >= mss_pkg::OFF_SLOT0) && (paddr <= mss_pkg::OFF_SLOT_END) && (paddr[1:0] == 2'h0);
	assign slot_addr = paddr[5:2];

	// map each select bit through its terminal field
	always_comb
	begin
		logic [3:0] fld;
		fld     = 4'h0;
		sel_nxt = 4'h0;
		for (int b = 0; b < mss_pkg::SEL_BITS; b++)
		begin
			fld = cfg_r.termmap[b*mss_pkg::TERM_FLD_W +: mss_pkg::TERM_FLD_W];
			// enable bit clear or terminal out of range leaves bit at zero
			if (fld[3] && (int'(fld[2:0]) < NUM_TERMS))
				sel_nxt[b] = term_r[fld[2:0]];
		end
	end

	// control, limit and terminal map
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_r.run     <= 1'b0;
			cfg_r.maxf    <= mss_pkg::MAXF_RST;
			cfg_r.termmap <= mss_pkg::TERMMAP_RST;
		end
		else if (wr_en)
		begin
			if (paddr == mss_pkg::OFF_CTRL)
				cfg_r.run <= pwdata[mss_pkg::CTRL_RUN];
			if (paddr == mss_pkg::OFF_MAXF)
				cfg_r.maxf <= pwdata[15:0];
			if (paddr == mss_pkg::OFF_TERMMAP)
				cfg_r.termmap <= pwdata[15:0];
		end
	end

	// edit buffer; in stop a change of selection reloads it from the new slot so the user edits that slot
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			edit_r <= mss_pkg::SLOT_RST;
		else if (wr_en && paddr == mss_pkg::OFF_EDIT)
			edit_r <= pwdata[FREQ_W-1:0];
		else if (!cfg_r.run && sel_nxt != speed_index)
			edit_r <= slot_r[sel_nxt];
	end

	// slot table; direct writes, store by slot number, or store by selection in stop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int s = 0; s < mss_pkg::NUM_SLOTS; s++)
				slot_r[s] <= mss_pkg::SLOT_RST;
		end
		else if (wr_en)
		begin
			if (slot_hit)
				slot_r[slot_addr] <= pwdata[FREQ_W-1:0];
			else if (paddr == mss_pkg::OFF_STORE)
			begin
				// store key: commit the edit buffer
				if (pwdata[mss_pkg::STORE_BY_SEL] && !cfg_r.run)
					slot_r[speed_index] <= edit_r;
				else if (!pwdata[mss_pkg::STORE_BY_SEL])
					slot_r[pwdata[3:0]] <= edit_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// selection and output frequency
	logic [FREQ_W-1:0] target;
	// clamp to limit; a slot above the limit runs at the limit
	assign target = (slot_r[speed_index] > cfg_r.maxf) ? cfg_r.maxf : slot_r[speed_index];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			speed_index <= 4'h0;
		else
			speed_index <= sel_nxt;
	end

	// active setting shows the clamped slot; output applies only in run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			active_r                 <= mss_pkg::SLOT_RST;
			output_frequency_monitor <= '0;
		end
		else
		begin
			active_r                 <= target;
			output_frequency_monitor <= cfg_r.run ? target : '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb read and answer; zero-wait, unmapped reads zero with error
	logic mapped;
	assign mapped = slot_hit || paddr == mss_pkg::OFF_CTRL || paddr == mss_pkg::OFF_STATUS
		|| paddr == mss_pkg::OFF_MAXF || paddr == mss_pkg::OFF_TERMMAP || paddr == mss_pkg::OFF_EDIT
		|| paddr == mss_pkg::OFF_STORE || paddr == mss_pkg::OFF_ACTIVE || paddr == mss_pkg::OFF_MONITOR;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else
		begin
			// ready in the first access cycle: setup registers the answer
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= 32'h0;
			if (psel && !penable && !pwrite)
			begin
				if (slot_hit)
					prdata <= {16'h0, slot_r[slot_addr]};
				else
					case (paddr)
						mss_pkg::OFF_CTRL:    prdata <= {31'h0, cfg_r.run};
						mss_pkg::OFF_STATUS:  prdata <= {16'h0, 7'h0, (slot_r[speed_index] > cfg_r.maxf), 4'h0, speed_index};
						mss_pkg::OFF_MAXF:    prdata <= {16'h0, cfg_r.maxf};
						mss_pkg::OFF_TERMMAP: prdata <= {16'h0, cfg_r.termmap};
						mss_pkg::OFF_EDIT:    prdata <= {16'h0, edit_r};
						mss_pkg::OFF_ACTIVE:  prdata <= {16'h0, active_r};
						mss_pkg::OFF_MONITOR: prdata <= {16'h0, output_frequency_monitor};
						default:              prdata <= 32'h0;
					endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions
	// named steps of the three store paths
	sequence store_sel_s;
		wr_en && paddr == mss_pkg::OFF_STORE && pwdata[mss_pkg::STORE_BY_SEL] && !cfg_r.run;
	endsequence

	// store into an explicit slot number
	sequence store_idx_s;
		wr_en && paddr == mss_pkg::OFF_STORE && !pwdata[mss_pkg::STORE_BY_SEL];
	endsequence

	// store by selection while running must be dropped
	sequence store_run_s;
		wr_en && paddr == mss_pkg::OFF_STORE && pwdata[mss_pkg::STORE_BY_SEL] && cfg_r.run;
	endsequence

	// output side: limit, stop and tracking
	// monitor never above the limit it was computed with
	monitor_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
		output_frequency_monitor <= $past(cfg_r.maxf)) else $error("monitor above limit");

	// active setting clamped the same way
	active_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
		active_r <= $past(cfg_r.maxf)) else $error("active above limit");

	// nothing reaches the motor in stop
	stop_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(cfg_r.run) |-> output_frequency_monitor == '0) else $error("output in stop");

	// monitor follows the clamped slot while running
	run_track_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(cfg_r.run) |-> output_frequency_monitor == $past(target)) else $error("monitor not tracking");

	// slot zero picked by the all-zero index
	slot_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		speed_index == 4'h0 && slot_r[0] <= cfg_r.maxf |=> active_r == $past(slot_r[0])) else $error("slot zero");

	// selection path: synchroniser and decode
	// index follows the decoded selection one cycle later
	index_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		speed_index == $past(sel_nxt)) else $error("index lag");

	// a disabled field for select bit zero never sets that bit
	unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cfg_r.termmap[3] |-> !sel_nxt[0]) else $error("unassigned bit nonzero");

	// agreeing late stages are taken
	sync_agree_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(sync2_r) == $past(sync3_r) |-> term_r == $past(sync3_r)) else $error("terminal not taken");

	// disagreeing late stages hold terminal zero at its old level, so a glitch is not seen
	term_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(sync2_r[0]) != $past(sync3_r[0]) |-> term_r[0] == $past(term_r[0])) else $error("terminal glitch");

	// slot table and edit buffer
	// store by selection lands in the selected slot
	store_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
		store_sel_s |=> slot_r[$past(speed_index)] == $past(edit_r)) else $error("store lost");

	// store by number lands in the named slot
	store_index_a: assert property (@(posedge pclk) disable iff (!presetn)
		store_idx_s |=> slot_r[$past(pwdata[3:0])] == $past(edit_r)) else $error("indexed store lost");

	// store by selection in run leaves the slot alone
	run_store_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
		store_run_s |=> slot_r[$past(speed_index)] == $past(slot_r[speed_index])) else $error("store in run");

	// no write, no change to slot zero
	no_store_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |=> slot_r[0] == $past(slot_r[0])) else $error("slot changed without store");

	// direct slot writes land
	slot_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && slot_hit |=> slot_r[$past(slot_addr)] == $past(pwdata[FREQ_W-1:0])) else $error("slot write lost");

	// edit buffer takes a bus write
	edit_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == mss_pkg::OFF_EDIT |=> edit_r == $past(pwdata[FREQ_W-1:0])) else $error("edit lost");

	// new selection in stop loads that slot for editing
	edit_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_en && paddr == mss_pkg::OFF_EDIT) && !cfg_r.run && sel_nxt != speed_index
		|=> edit_r == $past(slot_r[sel_nxt])) else $error("edit not reloaded");

	// otherwise the edit buffer holds
	edit_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_en && paddr == mss_pkg::OFF_EDIT) && (cfg_r.run || sel_nxt == speed_index)
		|=> $stable(edit_r)) else $error("edit drifted");

	// configuration writes
	ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == mss_pkg::OFF_CTRL |=> cfg_r.run == $past(pwdata[0])) else $error("run lost");

	maxf_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == mss_pkg::OFF_MAXF |=> cfg_r.maxf == $past(pwdata[15:0])) else $error("limit lost");

	termmap_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == mss_pkg::OFF_TERMMAP |=> cfg_r.termmap == $past(pwdata[15:0])) else $error("map lost");

	// bus answer
	// one ready cycle per setup
	pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready) else $error("pready timing");

	// no ready without a transfer
	pready_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!psel |=> !pready) else $error("stray pready");

	// unmapped address answers with an error
	err_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !mapped |=> pslverr) else $error("missing error");

	// mapped address answers clean
	no_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && mapped |=> !pslverr) else $error("false error");

	// sixteen-bit values leave the upper half zero
	prdata_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> prdata[31:16] == 16'h0) else $error("upper read data set");
endmodule
